// ### core/weigh_defines.vh
// register map, field positions, command and exception codes of the weighing register bank
// assumes a frame decoder outside that hands over one decoded register access at a time
`ifndef WEIGH_DEFINES_VH
`define WEIGH_DEFINES_VH

`define ADDR_COMMAND_WORD       16'h9C46
`define ADDR_WEIGH_FLAGS        16'h9C47
`define ADDR_DIVISION_AND_UNIT  16'h9C4E
`define ADDR_DIGITAL_INPUTS     16'h9C5D
`define ADDR_DIGITAL_OUTPUTS    16'h9C5E
`define ADDR_ANALOG_ZERO_HI     16'h9C6B
`define ADDR_ANALOG_ZERO_LO     16'h9C6C
`define ADDR_ANALOG_SPAN_HI     16'h9C6D
`define ADDR_ANALOG_SPAN_LO     16'h9C6E
`define ADDR_PASSWORD_SEED      16'h9C6F
`define ADDR_ID_PASSWORD        16'h9C70

`define ST_LOAD_CELL_ERR   0
`define ST_ADC_FAULT       1
`define ST_OVER_MAX_9E     2
`define ST_OVER_110PCT     3
`define ST_GROSS_RANGE     4
`define ST_NET_RANGE       5
`define ST_BELOW_M20E      6
`define ST_GROSS_NEG       7
`define ST_NET_NEG         8
`define ST_PEAK_NEG        9
`define ST_NET_MODE        10
`define ST_STABLE          11
`define ST_NEAR_ZERO       12

`define WEIGHT_LIMIT       32'h000F423F
`define UNIT_POUNDS        8'h03
`define UNIT_KILOGRAMS     8'h00
`define NUM_DIN            2
`define NUM_DOUT           3

`define CMD_NONE           16'h0000
`define CMD_TARE_ON        16'h0007
`define CMD_ZERO           16'h0008
`define CMD_TARE_OFF       16'h0009
`define CMD_KEYPAD_LOCK    16'h0015
`define CMD_ALL_UNLOCK     16'h0016
`define CMD_ALL_LOCK       16'h0017
`define CMD_SAVE_NV        16'h0063
`define CMD_CAL_ZERO       16'h0064
`define CMD_CAL_FIRST      16'h0065
`define CMD_CAL_CANCEL     16'h0068
`define CMD_CAL_ADD        16'h006A
`define CMD_SEND_ID        16'h0078
`define CMD_SEND_PASSWORD  16'h0079
`define CMD_PRESET_TARE    16'h0082

`define FUNC_READ_MULTI    8'h03
`define FUNC_WRITE_SINGLE  8'h06
`define FUNC_WRITE_MULTI   8'h10

`define EXC_NONE           2'h0
`define EXC_ILLEGAL_FUNC   2'h1
`define EXC_ILLEGAL_ADDR   2'h2
`define EXC_ILLEGAL_VALUE  2'h3

`define SEED_RESET         16'hACE1

`endif

// ### core/input_sync.v
// three-stage synchroniser with agreement filter for asynchronous pin inputs
// assumes the pins are slow compared with sys_clk
`timescale 1ns/100ps
module input_sync
#(
  parameter WIDTH = 2
)
(
  input  wire             sys_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      always @(posedge sys_clk)
      begin
        if (!rst_n)
        begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end
        else
        begin
          s1_q <= pin_in[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          // first stage is never compared, only the settled pair
          if (s2_q == s3_q)
            lvl_q <= s3_q;
        end
      end
      assign level_out[i] = lvl_q;
    end
  endgenerate

endmodule // input_sync

// ### core/weighing_status_command_regs.v
// register bank of a weighing instrument: status, i/o, descriptor, command and unlock logic
// assumes a frame decoder outside delivers one register access per req_valid pulse
//
// Overview of operation
// - fault flags in status bits 0 to 3
// - range flags bits 4, 5; below -20e bit 6
// - bit 7 follows gross weight sign
// - bits 8, 9 are net and peak signs
// - bits 10-12: net mode, stable, near zero
// - inputs 1, 2 on bits 0, 1, read only
// - outputs 1 to 3 on bits 0 to 2
// - output write needs host control configuration
// - descriptor: unit high byte, division low byte
// - division codes 0 to 18
// - units kg, g, t, lb; lb only under regulation
// - commands 0, 7, 8, 9, 130 decoded
// - command 21 locks keypad, 23 locks keypad and display, 22 unlocks both
// - span word pairs then command 99 saves
// - calibration commands only with qualified access
// - good password grants access, clears seed
// - access always locked after power-up
// - span values volatile, zero after reset even after save command
// - exception codes 1, 2, 3 for bad requests
`timescale 1ns/100ps
`include "weigh_defines.vh"
module weighing_status_command_regs
#(
  parameter [15:0] PASSWORD_KEY = 16'h5A3C
)
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        req_valid,
  input  wire [7:0]  req_func,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_wdata,
  output wire        rsp_valid,
  output wire [15:0] rsp_data,
  output wire [1:0]  rsp_exc,
  input  wire        load_cell_err,
  input  wire        adc_fault,
  input  wire        over_max_9e,
  input  wire        over_110pct,
  input  wire        below_minus_20e,
  input  wire        weight_stable,
  input  wire        near_zero,
  input  wire [31:0] gross_weight,
  input  wire [31:0] net_weight,
  input  wire [31:0] peak_weight,
  input  wire [7:0]  division_code,
  input  wire [7:0]  unit_parameter,
  input  wire        pound_regulation,
  input  wire [1:0]  din_pins,
  input  wire [2:0]  host_driven_output_setting,
  output wire [2:0]  dout_pins,
  output wire        net_display,
  output wire        keypad_locked,
  output wire        display_locked,
  output wire        access_granted,
  output wire        zero_pulse,
  output wire        preset_tare_pulse,
  output wire        save_nv_pulse,
  output wire        cal_zero_pulse,
  output wire        cal_first_pulse,
  output wire        cal_cancel_pulse,
  output wire        cal_add_pulse,
  output wire [31:0] analog_zero_weight,
  output wire [31:0] analog_span_weight
);

  reg  [15:0] seed_gen_q;
  reg  [15:0] seed_q;
  reg  [15:0] id_password_q;
  reg  [15:0] id_code_q;
  reg         access_q;
  reg         tare_q;
  reg         keypad_q;
  reg         display_q;
  reg  [2:0]  dout_q;
  reg  [15:0] zero_hi_q;
  reg  [15:0] zero_lo_q;
  reg  [15:0] span_hi_q;
  reg  [15:0] span_lo_q;
  reg         rsp_valid_q;
  reg  [15:0] rsp_data_q;
  reg  [1:0]  rsp_exc_q;
  // one-cycle command pulses: zero, preset, save, cal zero, first, cancel, add
  reg  [6:0]  pulse_q;
  reg  [15:0] status_w;
  reg  [15:0] rd_data;
  reg         rd_ok;
  reg         wr_ok;
  reg         cmd_ok;
  reg  [1:0]  exc;
  reg  [7:0]  unit_w;
  wire [1:0]  din_w;
  wire        is_read;
  wire        is_write;
  wire        password_match;
  wire        cmd_write;

  input_sync #(.WIDTH(`NUM_DIN)) input_sync_inst
  (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .pin_in    (din_pins),
    .level_out (din_w)
  );

  assign is_read  = (req_func == `FUNC_READ_MULTI);
  assign is_write = (req_func == `FUNC_WRITE_SINGLE) || (req_func == `FUNC_WRITE_MULTI);
  assign password_match = (id_password_q == (seed_q ^ id_code_q ^ PASSWORD_KEY));
  assign cmd_write = req_valid && is_write && (req_addr == `ADDR_COMMAND_WORD);

  always @*
  begin
    status_w = 16'h0000;
    status_w[`ST_LOAD_CELL_ERR] = load_cell_err;
    status_w[`ST_ADC_FAULT]     = adc_fault;
    status_w[`ST_OVER_MAX_9E]   = over_max_9e;
    status_w[`ST_OVER_110PCT]   = over_110pct;
    status_w[`ST_GROSS_RANGE] = ($signed(gross_weight) > $signed(`WEIGHT_LIMIT)) ||
                                ($signed(gross_weight) < -$signed(`WEIGHT_LIMIT));
    status_w[`ST_NET_RANGE]   = ($signed(net_weight) > $signed(`WEIGHT_LIMIT)) ||
                                ($signed(net_weight) < -$signed(`WEIGHT_LIMIT));
    status_w[`ST_BELOW_M20E]  = below_minus_20e;
    status_w[`ST_GROSS_NEG] = gross_weight[31];
    status_w[`ST_NET_NEG]  = net_weight[31];
    status_w[`ST_PEAK_NEG] = peak_weight[31];
    status_w[`ST_NET_MODE]  = tare_q;
    status_w[`ST_STABLE]    = weight_stable;
    status_w[`ST_NEAR_ZERO] = near_zero;
  end

  // pounds hidden unless its regulation is active
  always @*
  begin
    if ((unit_parameter == `UNIT_POUNDS) && !pound_regulation)
      unit_w = `UNIT_KILOGRAMS;
    else
      unit_w = unit_parameter;
  end

  // read decode; anything unlisted is an unavailable address
  always @*
  begin
    rd_ok   = 1'b1;
    rd_data = 16'h0000;
    case (req_addr)
      `ADDR_WEIGH_FLAGS       : rd_data = status_w;
      // unit high byte, division low byte
      `ADDR_DIVISION_AND_UNIT : rd_data = {unit_w, division_code};
      // unused input and output bits read zero
      `ADDR_DIGITAL_INPUTS    : rd_data = {14'h0000, din_w};
      // outputs 1 to 3 on bits 0 to 2
      // output states readable at any time
      `ADDR_DIGITAL_OUTPUTS   : rd_data = {13'h0000, dout_q};
      `ADDR_ANALOG_ZERO_HI    : rd_data = zero_hi_q;
      `ADDR_ANALOG_ZERO_LO    : rd_data = zero_lo_q;
      `ADDR_ANALOG_SPAN_HI    : rd_data = span_hi_q;
      `ADDR_ANALOG_SPAN_LO    : rd_data = span_lo_q;
      `ADDR_PASSWORD_SEED     : rd_data = seed_q;
      `ADDR_ID_PASSWORD       : rd_data = id_password_q;
      default                 : rd_ok = 1'b0;
    endcase
  end

  // writes to status, descriptor and seed are refused
  always @*
  begin
    case (req_addr)
      `ADDR_COMMAND_WORD, `ADDR_DIGITAL_INPUTS, `ADDR_DIGITAL_OUTPUTS,
      `ADDR_ANALOG_ZERO_HI, `ADDR_ANALOG_ZERO_LO, `ADDR_ANALOG_SPAN_HI, `ADDR_ANALOG_SPAN_LO,
      `ADDR_ID_PASSWORD : wr_ok = 1'b1;
      default           : wr_ok = 1'b0;
    endcase
  end

  always @*
  begin
    case (req_wdata)
      `CMD_NONE, `CMD_TARE_ON, `CMD_ZERO, `CMD_TARE_OFF, `CMD_KEYPAD_LOCK,
      `CMD_ALL_UNLOCK, `CMD_ALL_LOCK, `CMD_SAVE_NV, `CMD_SEND_ID,
      `CMD_PRESET_TARE   : cmd_ok = 1'b1;
      `CMD_CAL_ZERO, `CMD_CAL_FIRST, `CMD_CAL_CANCEL, `CMD_CAL_ADD : cmd_ok = access_q;
      // a wrong password is answered as an invalid value
      `CMD_SEND_PASSWORD : cmd_ok = password_match;
      default            : cmd_ok = 1'b0;
    endcase
  end

  always @*
  begin
    if (!is_read && !is_write)
      exc = `EXC_ILLEGAL_FUNC;
    else if (is_read ? !rd_ok : !wr_ok)
      exc = `EXC_ILLEGAL_ADDR;
    else if (cmd_write && !cmd_ok)
      exc = `EXC_ILLEGAL_VALUE;
    else
      exc = `EXC_NONE;
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      seed_gen_q    <= `SEED_RESET;
      seed_q        <= 16'h0000;
      id_password_q <= 16'h0000;
      id_code_q     <= 16'h0000;
      access_q      <= 1'b0;
      tare_q        <= 1'b0;
      keypad_q      <= 1'b0;
      display_q     <= 1'b0;
      dout_q        <= 3'h0;
      // span values volatile, zero after power-up
      zero_hi_q     <= 16'h0000;
      zero_lo_q     <= 16'h0000;
      span_hi_q     <= 16'h0000;
      span_lo_q     <= 16'h0000;
      rsp_valid_q   <= 1'b0;
      rsp_data_q    <= 16'h0000;
      rsp_exc_q     <= `EXC_NONE;
      pulse_q       <= 7'h00;
    end
    else
    begin
      // free-running lfsr so each seed is hard to predict
      seed_gen_q   <= {seed_gen_q[14:0],
                       seed_gen_q[15] ^ seed_gen_q[13] ^ seed_gen_q[12] ^ seed_gen_q[10]};
      rsp_valid_q  <= req_valid;
      pulse_q      <= 7'h00;
      if (req_valid)
      begin
        rsp_exc_q  <= exc;
        rsp_data_q <= is_read ? rd_data : req_wdata;
      end
      if (req_valid && is_write && (exc == `EXC_NONE))
      begin
        case (req_addr)
          // only host-controlled outputs take the write
          `ADDR_DIGITAL_OUTPUTS :
            dout_q <= (req_wdata[2:0] & host_driven_output_setting) |
                      (dout_q & ~host_driven_output_setting);
          // span word pairs take effect at once, held until rewritten or reset
          `ADDR_ANALOG_ZERO_HI : zero_hi_q <= req_wdata;
          `ADDR_ANALOG_ZERO_LO : zero_lo_q <= req_wdata;
          `ADDR_ANALOG_SPAN_HI : span_hi_q <= req_wdata;
          `ADDR_ANALOG_SPAN_LO : span_lo_q <= req_wdata;
          `ADDR_ID_PASSWORD    : id_password_q <= req_wdata;
          `ADDR_COMMAND_WORD :
            case (req_wdata)
              `CMD_TARE_ON     : tare_q <= 1'b1;
              `CMD_TARE_OFF    : tare_q <= 1'b0;
              `CMD_ZERO        : pulse_q[0] <= 1'b1;
              `CMD_PRESET_TARE : pulse_q[1] <= 1'b1;
              `CMD_KEYPAD_LOCK : keypad_q <= 1'b1;
              `CMD_ALL_UNLOCK :
              begin
                keypad_q  <= 1'b0;
                display_q <= 1'b0;
              end
              `CMD_ALL_LOCK :
              begin
                keypad_q  <= 1'b1;
                display_q <= 1'b1;
              end
              `CMD_SAVE_NV    : pulse_q[2] <= 1'b1;
              `CMD_CAL_ZERO   : pulse_q[3] <= 1'b1;
              `CMD_CAL_FIRST  : pulse_q[4] <= 1'b1;
              `CMD_CAL_CANCEL : pulse_q[5] <= 1'b1;
              `CMD_CAL_ADD    : pulse_q[6] <= 1'b1;
              // latch the id and hand out a fresh seed
              `CMD_SEND_ID :
              begin
                id_code_q <= id_password_q;
                seed_q    <= seed_gen_q;
              end
              `CMD_SEND_PASSWORD :
              begin
                access_q <= 1'b1;
                seed_q   <= 16'h0000;
              end
              default : ;
            endcase
          // digital_inputs accepts the write and changes nothing
          default : ;
        endcase
      end
    end
  end

  assign rsp_valid          = rsp_valid_q;
  assign rsp_data           = rsp_data_q;
  assign rsp_exc            = rsp_exc_q;
  assign dout_pins          = dout_q;
  assign net_display        = tare_q;
  assign keypad_locked      = keypad_q;
  assign display_locked     = display_q;
  assign access_granted     = access_q;
  assign zero_pulse         = pulse_q[0];
  assign preset_tare_pulse  = pulse_q[1];
  assign save_nv_pulse      = pulse_q[2];
  assign cal_zero_pulse     = pulse_q[3];
  assign cal_first_pulse    = pulse_q[4];
  assign cal_cancel_pulse   = pulse_q[5];
  assign cal_add_pulse      = pulse_q[6];
  assign analog_zero_weight = {zero_hi_q, zero_lo_q};
  assign analog_span_weight = {span_hi_q, span_lo_q};

endmodule // weighing_status_command_regs

// ### bench/weigh_regs_chk.sv
// assertions on the answer timing, command effects and output gating of the weighing register bank
// assumes one clock with synchronous active-low reset
`timescale 1ns/100ps
module weigh_regs_chk
(
  input wire        sys_clk,
  input wire        rst_n,
  input wire        req_valid,
  input wire [7:0]  req_func,
  input wire [15:0] req_addr,
  input wire [15:0] req_wdata,
  input wire        rsp_valid,
  input wire [15:0] rsp_data,
  input wire [31:0] gross_weight,
  input wire [2:0]  host_driven_output_setting,
  input wire [2:0]  dout_pins,
  input wire        net_display,
  input wire        keypad_locked,
  input wire        display_locked,
  input wire        access_granted,
  input wire        zero_pulse,
  input wire        save_nv_pulse,
  input wire        cal_zero_pulse,
  input wire        cal_add_pulse
);
  reg        cmd_q;
  reg [15:0] code_q;
  reg        stat_q;
  reg        sign_q;

  // remember what the previous edge took, so effects are tied to their cause
  always @(posedge sys_clk)
  begin
    cmd_q  <= req_valid && (req_func == 8'h06 || req_func == 8'h10) && req_addr == 16'h9C46;
    code_q <= req_wdata;
    stat_q <= req_valid && req_func == 8'h03 && req_addr == 16'h9C47;
    sign_q <= gross_weight[31];
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  answer_follows_a: assert property (req_valid |=> rsp_valid)
    else $error("no answer after a request");
  answer_cause_a: assert property (rsp_valid |-> $past(req_valid))
    else $error("answer without a request");
  status_sign_a: assert property (rsp_valid && stat_q |-> rsp_data[7] == sign_q)
    else $error("gross sign bit wrong");
  status_spare_a: assert property (rsp_valid && stat_q |-> rsp_data[15:13] == 3'h0)
    else $error("spare status bits set");
  net_on_a: assert property (cmd_q && code_q == 16'h0007 |-> net_display)
    else $error("net display not entered");
  net_off_a: assert property (cmd_q && code_q == 16'h0009 |-> !net_display)
    else $error("net display not left");
  zero_cause_a: assert property (zero_pulse |-> cmd_q && code_q == 16'h0008)
    else $error("zeroing pulse without its command");
  lock_both_a: assert property (cmd_q && code_q == 16'h0017 |-> keypad_locked && display_locked)
    else $error("keypad and display not locked");
  unlock_both_a: assert property (cmd_q && code_q == 16'h0016 |-> !keypad_locked && !display_locked)
    else $error("keypad and display not unlocked");
  save_pulse_a: assert property (cmd_q && code_q == 16'h0063 |-> save_nv_pulse)
    else $error("save pulse missing");
  cal_gate_a: assert property (cal_zero_pulse || cal_add_pulse |-> access_granted)
    else $error("calibration pulse without access");
  access_hold_a: assert property (access_granted |=> access_granted)
    else $error("access dropped without reset");
  dout_gate_a: assert property (((dout_pins ^ $past(dout_pins)) & ~$past(host_driven_output_setting)) == 3'h0)
    else $error("output changed without host control");
endmodule // weigh_regs_chk

bind weighing_status_command_regs weigh_regs_chk weigh_regs_chk_inst
(
  .sys_clk, .rst_n, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid, .rsp_data,
  .gross_weight, .host_driven_output_setting, .dout_pins, .net_display, .keypad_locked,
  .display_locked, .access_granted, .zero_pulse, .save_nv_pulse, .cal_zero_pulse, .cal_add_pulse
);

// ### bench/host_master.sv
// host-side bus master issuing one register access per request pulse
// assumes the answer arrives on the edge after the request is taken
`timescale 1ns/100ps
module host_master
(
  input  wire        sys_clk,
  input  wire        rsp_valid,
  input  wire [15:0] rsp_data,
  input  wire [1:0]  rsp_exc,
  input  wire [9:0]  watch,
  output reg         req_valid,
  output reg  [7:0]  req_func,
  output reg  [15:0] req_addr,
  output reg  [15:0] req_wdata
);
  reg [15:0] got_data;
  reg [1:0]  got_exc;
  reg [9:0]  got_watch;

  initial
  begin
    req_valid = 1'b0;
    req_func  = 8'h00;
    req_addr  = 16'h0000;
    req_wdata = 16'h0000;
  end

  task access(input [7:0] f, input [15:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_func  <= f;
      req_addr  <= a;
      req_wdata <= d;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      // idle address and data are scrambled so nothing relies on stale request values
      req_addr  <= ~a;
      req_wdata <= ~d;
      @(posedge sys_clk);
      got_data  = rsp_valid ? rsp_data : 16'hXXXX;
      got_exc   = rsp_valid ? rsp_exc : 2'bXX;
      got_watch = watch;
      #1;
    end
  endtask

  task unlock(input [15:0] id, input [15:0] key);
    begin
      access(8'h06, 16'h9C70, id);
      access(8'h06, 16'h9C46, 16'h0078);
      access(8'h03, 16'h9C6F, 16'h0000);
      access(8'h06, 16'h9C70, got_data ^ id ^ key);
      access(8'h06, 16'h9C46, 16'h0079);
    end
  endtask
endmodule // host_master

// ### bench/weighing_status_command_regs_test.sv
// self-checking bench for the weighing register bank
// assumes host_master samples the answer and the watched outputs one edge after each request
`timescale 1ns/100ps
module weighing_status_command_regs_test;
  localparam [15:0] PW_KEY = 16'h5A3C;
  reg         sys_clk;
  reg         rst_n;
  reg  [6:0]  flags;
  reg  [31:0] gross;
  reg  [31:0] net;
  reg  [31:0] peak;
  reg  [7:0]  unit;
  reg         pound;
  reg  [1:0]  din;
  reg  [2:0]  owner;
  wire        req_valid;
  wire [7:0]  req_func;
  wire [15:0] req_addr;
  wire [15:0] req_wdata;
  wire        rsp_valid;
  wire [15:0] rsp_data;
  wire [1:0]  rsp_exc;
  wire [2:0]  dout;
  wire [9:0]  watch;
  wire [31:0] zero_w;
  wire [31:0] span_w;
  wire        access;
  integer     n_errors;
  integer     check_count;
  integer     cycles;

  weighing_status_command_regs #(.PASSWORD_KEY(PW_KEY)) weighing_status_command_regs_inst
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
    .load_cell_err(flags[0]), .adc_fault(flags[1]), .over_max_9e(flags[2]), .over_110pct(flags[3]),
    .below_minus_20e(flags[4]), .weight_stable(flags[5]), .near_zero(flags[6]),
    .gross_weight(gross), .net_weight(net), .peak_weight(peak), .division_code(8'h12),
    .unit_parameter(unit), .pound_regulation(pound), .din_pins(din), .host_driven_output_setting(owner),
    .dout_pins(dout), .net_display(watch[2]), .keypad_locked(watch[1]), .display_locked(watch[0]),
    .access_granted(access), .zero_pulse(watch[9]), .preset_tare_pulse(watch[8]), .save_nv_pulse(watch[7]),
    .cal_zero_pulse(watch[6]), .cal_first_pulse(watch[5]), .cal_cancel_pulse(watch[4]),
    .cal_add_pulse(watch[3]), .analog_zero_weight(zero_w), .analog_span_weight(span_w)
  );

  host_master host_master_inst
  (
    .sys_clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_exc(rsp_exc), .watch(watch),
    .req_valid(req_valid), .req_func(req_func), .req_addr(req_addr), .req_wdata(req_wdata)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end

  task chk(input [8*8:1] what, input [31:0] exp, input [31:0] got);
    begin
      check_count = check_count + 1;
      if (exp !== got)
      begin
        n_errors = n_errors + 1;
        $display("BAD %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  // answer packed as exception code above data
  task acc(input [7:0] f, input [15:0] a, input [15:0] d, input [17:0] exp);
    begin
      host_master_inst.access(f, a, d);
      chk("response", {14'h0, exp}, {14'h0, host_master_inst.got_exc, host_master_inst.got_data});
    end
  endtask

  task rd(input [15:0] a, input [15:0] v);
    acc(8'h03, a, 16'h0000, {2'h0, v});
  endtask

  task wr(input [15:0] a, input [15:0] d, input [1:0] e);
    acc(8'h06, a, d, {e, d});
  endtask

  task ex(input [7:0] f, input [15:0] a, input [1:0] e);
    begin
      host_master_inst.access(f, a, 16'h0000);
      chk("exc", {30'h0, e}, {30'h0, host_master_inst.got_exc});
    end
  endtask

  task cmd(input [15:0] c, input [1:0] e, input [9:0] w);
    begin
      wr(16'h9C46, c, e);
      chk("watch", {22'h0, w}, {22'h0, host_master_inst.got_watch});
    end
  endtask

  initial
  begin
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_n = 1'b0;
    flags = 7'h35;
    gross = 32'hFFFFFFFF;
    net = 32'h000F4240;
    peak = 32'hFFFFFFFB;
    unit = 8'h03;
    pound = 1'b0;
    din = 2'h2;
    owner = 3'h5;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(16'h9C47, 16'h0AE5);
    @(posedge sys_clk);
    flags <= 7'h00;
    gross <= 32'h000F423F;
    net <= 32'hFFF0BDC1;
    peak <= 32'h00000000;
    rd(16'h9C47, 16'h0100);
    rd(16'h9C4E, 16'h0012);
    @(posedge sys_clk);
    pound <= 1'b1;
    rd(16'h9C4E, 16'h0312);
    @(posedge sys_clk);
    unit <= 8'h02;
    pound <= 1'b0;
    rd(16'h9C4E, 16'h0212);
    $display("status and descriptor test done");
    rd(16'h9C5D, 16'h0002);
    wr(16'h9C5D, 16'hFFFF, 2'h0);
    rd(16'h9C5D, 16'h0002);
    wr(16'h9C5E, 16'hFFFF, 2'h0);
    rd(16'h9C5E, 16'h0005);
    @(posedge sys_clk);
    owner <= 3'h2;
    wr(16'h9C5E, 16'h0002, 2'h0);
    chk("outputs", 32'h7, {29'h0, dout});
    @(posedge sys_clk);
    owner <= 3'h1;
    wr(16'h9C5E, 16'h0000, 2'h0);
    rd(16'h9C5E, 16'h0006);
    $display("input and output test done");
    cmd(16'h0000, 2'h0, 10'h000);
    cmd(16'h0007, 2'h0, 10'h004);
    @(posedge sys_clk);
    flags <= 7'h4A;
    gross <= 32'h000F4240;
    net <= 32'hFFF0BDC0;
    rd(16'h9C47, 16'h153A);
    cmd(16'h0008, 2'h0, 10'h204);
    cmd(16'h0082, 2'h0, 10'h104);
    cmd(16'h0009, 2'h0, 10'h000);
    cmd(16'h0015, 2'h0, 10'h002);
    cmd(16'h0017, 2'h0, 10'h003);
    cmd(16'h0016, 2'h0, 10'h000);
    cmd(16'h0005, 2'h3, 10'h000);
    cmd(16'h0064, 2'h3, 10'h000);
    cmd(16'h0065, 2'h3, 10'h000);
    cmd(16'h0068, 2'h3, 10'h000);
    cmd(16'h006A, 2'h3, 10'h000);
    $display("command test done");
    wr(16'h9C6B, 16'h1234, 2'h0);
    wr(16'h9C6C, 16'h5678, 2'h0);
    wr(16'h9C6D, 16'h00AB, 2'h0);
    acc(8'h10, 16'h9C6E, 16'hCDEF, 18'h0CDEF);
    rd(16'h9C6B, 16'h1234);
    chk("zero", 32'h12345678, zero_w);
    chk("span", 32'h00ABCDEF, span_w);
    cmd(16'h0063, 2'h0, 10'h080);
    ex(8'h04, 16'h9C47, 2'h1);
    ex(8'h03, 16'h9C46, 2'h2);
    ex(8'h03, 16'h9C50, 2'h2);
    wr(16'h9C47, 16'h0001, 2'h2);
    wr(16'h9C4E, 16'h0001, 2'h2);
    $display("span and refusal test done");
    host_master_inst.unlock(16'h1357, 16'h0000);
    chk("exc", 32'h3, {30'h0, host_master_inst.got_exc});
    chk("access", 32'h0, {31'h0, access});
    host_master_inst.unlock(16'h1357, PW_KEY);
    chk("access", 32'h1, {31'h0, access});
    rd(16'h9C6F, 16'h0000);
    cmd(16'h0064, 2'h0, 10'h040);
    cmd(16'h0065, 2'h0, 10'h020);
    cmd(16'h0068, 2'h0, 10'h010);
    cmd(16'h006A, 2'h0, 10'h008);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("access", 32'h0, {31'h0, access});
    chk("span", 32'h0, span_w);
    cmd(16'h0064, 2'h3, 10'h000);
    $display("access test done");
    tally_and_finish;
  end
endmodule // weighing_status_command_regs_test
